/* File: hdl/acd_datapath.v */
// Accumulator datapath with four-flag ALU and data transfer operations
`timescale 1ns/1ps
`include "acd_map.vh"
module acd_datapath #(
  parameter DW = 8,
  parameter TW = 16
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Instruction issue
  input wire op_valid,
  input wire [4:0] op_code,
  input wire [DW-1:0] op_imm,
  input wire [DW-1:0] op_addr,
  output wire op_busy,
  output reg op_done,
  // Operand inputs
  input wire [DW-1:0] mem_rdata,
  input wire [DW-1:0] mem_rdata_hi,
  input wire [DW-1:0] io_rdata,
  input wire [TW-1:0] timer_value,
  // Memory and I/O writes
  output reg mem_we,
  output reg mem_we_hi,
  output reg [DW-1:0] mem_waddr,
  output reg [DW-1:0] mem_wdata,
  output reg [DW-1:0] mem_wdata_hi,
  output reg io_we,
  output reg [DW-1:0] io_wdata,
  output reg timer_we,
  output reg [TW-1:0] timer_wdata,
  // Indirect read address request
  output reg ind_req,
  output reg [DW-1:0] ind_addr,
  // Architectural state
  output reg [DW-1:0] working_register,
  output reg [DW-1:0] push_pointer,
  output wire result_null_bit,
  output wire unsigned_out_bit,
  output wire half_byte_out_bit,
  output wire signed_range_bit,
  output wire bit_addr_ok
);
  // ==========================================================
  // State
  localparam ST_IDLE = 2'b01;
  localparam ST_IND = 2'b10;
  reg [1:0] st_q;         // Indirect sequencer
  reg [4:0] pend_op_q;    // Indirect operation in flight
  reg [3:0] flag_q;       // Z, C, AC, OV
  assign result_null_bit = flag_q[`ACD_FLAG_Z];
  assign unsigned_out_bit = flag_q[`ACD_FLAG_C];
  assign half_byte_out_bit = flag_q[`ACD_FLAG_AC];
  assign signed_range_bit = flag_q[`ACD_FLAG_OV];
  // Advisory only: the core must not issue bit ops above this address
  assign bit_addr_ok = (op_addr <= `ACD_BIT_LIMIT);
  // New ops are refused while the indirect move finishes
  assign op_busy = (st_q == ST_IND);
  // ==========================================================
  // Adder operand selection
  reg [DW-1:0] opa;       // First addend
  reg [DW-1:0] opb;       // Second addend, already inverted for subtract
  reg cin;                // Carry into bit 0
  reg is_sub;             // Carry flag reported as borrow
  reg is_alu;             // Arithmetic writes all flags
  reg to_mem;             // Result goes to memory instead of register
  always @* begin
    opa = working_register;
    opb = {DW{1'b0}};
    cin = 1'b0;
    is_sub = 1'b0;
    is_alu = 1'b1;
    to_mem = 1'b0;
    case (op_code)
      `ACD_OP_ADD_AI: begin
        opb = op_imm;
      end
      `ACD_OP_ADD_AM: begin
        opb = mem_rdata;
      end
      `ACD_OP_ADD_MA: begin
        opb = mem_rdata;
        to_mem = 1'b1;
      end
      `ACD_OP_ADDC_AM: begin
        opb = mem_rdata;
        cin = unsigned_out_bit;
      end
      `ACD_OP_ADDC_MA: begin
        opb = mem_rdata;
        cin = unsigned_out_bit;
        to_mem = 1'b1;
      end
      `ACD_OP_ADDC_A: begin
        cin = unsigned_out_bit;
      end
      `ACD_OP_ADDC_M: begin
        opa = mem_rdata;
        cin = unsigned_out_bit;
        to_mem = 1'b1;
      end
      `ACD_OP_NADD_AM: begin
        // Destination is the register: memory minus register
        opa = mem_rdata;
        opb = ~working_register;
        cin = 1'b1;
        is_sub = 1'b1;
      end
      `ACD_OP_NADD_MA: begin
        opb = ~mem_rdata;
        cin = 1'b1;
        is_sub = 1'b1;
        to_mem = 1'b1;
      end
      `ACD_OP_SUB_AI: begin
        opb = ~op_imm;
        cin = 1'b1;
        is_sub = 1'b1;
      end
      `ACD_OP_SUB_AM: begin
        opb = ~mem_rdata;
        cin = 1'b1;
        is_sub = 1'b1;
      end
      `ACD_OP_SUB_MA: begin
        opa = mem_rdata;
        opb = ~working_register;
        cin = 1'b1;
        is_sub = 1'b1;
        to_mem = 1'b1;
      end
      `ACD_OP_SUBC_AM: begin
        // Carry in of 1 minus borrow folds the extra subtract in
        opb = ~mem_rdata;
        cin = ~unsigned_out_bit;
        is_sub = 1'b1;
      end
      `ACD_OP_SUBC_MA: begin
        opa = mem_rdata;
        opb = ~working_register;
        cin = ~unsigned_out_bit;
        is_sub = 1'b1;
        to_mem = 1'b1;
      end
      `ACD_OP_SUBC_A: begin
        opb = {DW{1'b1}};
        cin = ~unsigned_out_bit;
        is_sub = 1'b1;
      end
      `ACD_OP_SUBC_M: begin
        opa = mem_rdata;
        opb = {DW{1'b1}};
        cin = ~unsigned_out_bit;
        is_sub = 1'b1;
        to_mem = 1'b1;
      end
      `ACD_OP_INC_M: begin
        opa = mem_rdata;
        cin = 1'b1;
        to_mem = 1'b1;
      end
      `ACD_OP_DEC_M: begin
        // Decrement is add of all ones, carry reported as borrow
        opa = mem_rdata;
        opb = {DW{1'b1}};
        is_sub = 1'b1;
        to_mem = 1'b1;
      end
      default: begin
        is_alu = 1'b0;
      end
    endcase
  end
  // ==========================================================
  // Adder and flag generation
  wire [4:0] lo_sum;      // Low nibble with its carry out
  wire [DW:0] full_sum;   // Whole byte with its carry out
  wire [DW-1:0] alu_res;
  wire [3:0] alu_flags;
  assign lo_sum = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
  assign full_sum = {1'b0, opa} + {1'b0, opb} + {{DW{1'b0}}, cin};
  assign alu_res = full_sum[DW-1:0];
  assign alu_flags[`ACD_FLAG_Z] = (alu_res == {DW{1'b0}});
  // Subtract reports borrow, the inverse of the adder carry
  assign alu_flags[`ACD_FLAG_C] = full_sum[DW] ^ is_sub;
  assign alu_flags[`ACD_FLAG_AC] = lo_sum[4] ^ is_sub;
  // Same-sign addends giving an opposite-sign sum
  assign alu_flags[`ACD_FLAG_OV] = (opa[DW-1] == opb[DW-1]) &&
                                   (alu_res[DW-1] != opa[DW-1]);
  // ==========================================================
  // Architectural update
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      pend_op_q <= `ACD_OP_NOP;
      flag_q <= `ACD_FLAG_RST;
      working_register <= `ACD_ACC_RST;
      push_pointer <= `ACD_PP_RST;
      op_done <= 1'b0;
      mem_we <= 1'b0;
      mem_we_hi <= 1'b0;
      mem_waddr <= {DW{1'b0}};
      mem_wdata <= {DW{1'b0}};
      mem_wdata_hi <= {DW{1'b0}};
      io_we <= 1'b0;
      io_wdata <= {DW{1'b0}};
      timer_we <= 1'b0;
      timer_wdata <= {TW{1'b0}};
      ind_req <= 1'b0;
      ind_addr <= {DW{1'b0}};
    end else begin
      // Strobes last one cycle
      op_done <= 1'b0;
      mem_we <= 1'b0;
      mem_we_hi <= 1'b0;
      io_we <= 1'b0;
      timer_we <= 1'b0;
      ind_req <= 1'b0;
      case (st_q)
        ST_IND: begin
          // Second cycle: pointed location is now on mem_rdata
          if (pend_op_q == `ACD_OP_IDX_RD) begin
            working_register <= mem_rdata;
          end else begin
            mem_we <= 1'b1;
            mem_waddr <= ind_addr;
            mem_wdata <= working_register;
          end
          op_done <= 1'b1;
          st_q <= ST_IDLE;
        end
        default: begin
          if (op_valid) begin
            op_done <= 1'b1;
            mem_waddr <= op_addr;
            if (is_alu) begin
              flag_q <= alu_flags;
              if (to_mem) begin
                mem_we <= 1'b1;
                mem_wdata <= alu_res;
              end else begin
                working_register <= alu_res;
              end
            end else begin
              case (op_code)
                `ACD_OP_MOV_AI: begin
                  working_register <= op_imm;
                end
                `ACD_OP_MOV_MA: begin
                  mem_we <= 1'b1;
                  mem_wdata <= working_register;
                end
                `ACD_OP_MOV_AM: begin
                  working_register <= mem_rdata;
                  flag_q[`ACD_FLAG_Z] <= (mem_rdata == {DW{1'b0}});
                end
                `ACD_OP_MOV_AIO: begin
                  working_register <= io_rdata;
                  flag_q[`ACD_FLAG_Z] <= (io_rdata == {DW{1'b0}});
                end
                `ACD_OP_MOV_IOA: begin
                  io_we <= 1'b1;
                  io_wdata <= working_register;
                end
                `ACD_OP_TLOAD: begin
                  // Low byte at the word address, high byte after it
                  mem_we <= 1'b1;
                  mem_we_hi <= 1'b1;
                  mem_wdata <= timer_value[DW-1:0];
                  mem_wdata_hi <= timer_value[TW-1:DW];
                end
                `ACD_OP_TSTORE: begin
                  timer_we <= 1'b1;
                  timer_wdata <= {mem_rdata_hi, mem_rdata};
                end
                `ACD_OP_IDX_RD, `ACD_OP_IDX_WR: begin
                  // First cycle fetches the pointer held in the word
                  ind_addr <= mem_rdata;
                  ind_req <= 1'b1;
                  pend_op_q <= op_code;
                  op_done <= 1'b0;
                  st_q <= ST_IND;
                end
                `ACD_OP_XCH: begin
                  working_register <= mem_rdata;
                  mem_we <= 1'b1;
                  mem_wdata <= working_register;
                end
                `ACD_OP_PUSHF: begin
                  mem_waddr <= push_pointer;
                  mem_we <= 1'b1;
                  mem_we_hi <= 1'b1;
                  mem_wdata <= working_register;
                  mem_wdata_hi <= {{(DW-4){1'b0}}, flag_q};
                  push_pointer <= push_pointer + `ACD_PP_STEP;
                end
                `ACD_OP_POPF: begin
                  // Core presents the bytes at pointer minus two
                  push_pointer <= push_pointer - `ACD_PP_STEP;
                  working_register <= mem_rdata;
                  flag_q <= mem_rdata_hi[3:0];
                end
                `ACD_OP_CLR_M: begin
                  mem_we <= 1'b1;
                  mem_wdata <= {DW{1'b0}};
                end
                default: begin // Unknown codes pulse done and load mem_waddr only
                end
              endcase
            end
          end
        end
      endcase
    end
  end
endmodule

/* File: hdl/acd_map.vh */
// Constants for the accumulator datapath: opcodes, flag positions, reset values
`ifndef ACD_MAP_VH
`define ACD_MAP_VH
// ==========================================================
// Operation codes
`define ACD_OP_NOP      5'h00
`define ACD_OP_MOV_AI   5'h01
`define ACD_OP_MOV_MA   5'h02
`define ACD_OP_MOV_AM   5'h03
`define ACD_OP_MOV_AIO  5'h04
`define ACD_OP_MOV_IOA  5'h05
`define ACD_OP_TLOAD    5'h06
`define ACD_OP_TSTORE   5'h07
`define ACD_OP_IDX_RD   5'h08
`define ACD_OP_IDX_WR   5'h09
`define ACD_OP_XCH      5'h0A
`define ACD_OP_PUSHF    5'h0B
`define ACD_OP_POPF     5'h0C
`define ACD_OP_ADD_AI   5'h0D
`define ACD_OP_ADD_AM   5'h0E
`define ACD_OP_ADD_MA   5'h0F
`define ACD_OP_ADDC_AM  5'h10
`define ACD_OP_ADDC_MA  5'h11
`define ACD_OP_ADDC_A   5'h12
`define ACD_OP_ADDC_M   5'h13
`define ACD_OP_NADD_AM  5'h14
`define ACD_OP_NADD_MA  5'h15
`define ACD_OP_SUB_AI   5'h16
`define ACD_OP_SUB_AM   5'h17
`define ACD_OP_SUB_MA   5'h18
`define ACD_OP_SUBC_AM  5'h19
`define ACD_OP_SUBC_MA  5'h1A
`define ACD_OP_SUBC_A   5'h1B
`define ACD_OP_SUBC_M   5'h1C
`define ACD_OP_INC_M    5'h1D
`define ACD_OP_DEC_M    5'h1E
`define ACD_OP_CLR_M    5'h1F
// ==========================================================
// Flag byte bit positions
`define ACD_FLAG_Z   0
`define ACD_FLAG_C   1
`define ACD_FLAG_AC  2
`define ACD_FLAG_OV  3
// ==========================================================
// Reset values, steps and the bit-operand address limit
`define ACD_ACC_RST   8'h00
`define ACD_FLAG_RST  4'h0
`define ACD_PP_RST    8'h00
`define ACD_PP_STEP   8'h02
`define ACD_BIT_LIMIT 8'h3F
`endif

/* File: dv/acd_datapath_assertions.sv */
// Port-level property checker for the accumulator datapath
`timescale 1ns/1ps
`include "acd_map.vh"
module acd_datapath_assertions #(
  parameter DW = 8,
  parameter TW = 16
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Issue side
  input wire op_valid,
  input wire op_busy,
  input wire [4:0] op_code,
  input wire [DW-1:0] op_imm,
  input wire [DW-1:0] mem_rdata,
  input wire [TW-1:0] timer_value,
  // Results
  input wire op_done,
  input wire ind_req,
  input wire mem_we,
  input wire mem_we_hi,
  input wire [DW-1:0] mem_wdata,
  input wire [DW-1:0] mem_wdata_hi,
  input wire [DW-1:0] working_register,
  input wire [DW-1:0] push_pointer,
  input wire result_null_bit,
  input wire unsigned_out_bit
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ==========================================================
  // Helpers
  // Operation accepted at this edge
  wire tk = op_valid && !op_busy;
  // Nine-bit sum for the immediate add, carry in the top bit
  wire [DW:0] sum = {1'b0, working_register} + {1'b0, op_imm};
  // ==========================================================
  // Properties
  chk_add_carry: assert property (
    tk && op_code == `ACD_OP_ADD_AI |=> op_done
    && {unsigned_out_bit, working_register} == $past(sum))
    else $error("immediate add gave wrong sum or carry");
  chk_zero_flag: assert property (
    tk && op_code == `ACD_OP_ADD_AI |=> result_null_bit == (working_register == 8'h00))
    else $error("zero flag does not match result");
  chk_load_zero: assert property (
    tk && op_code == `ACD_OP_MOV_AM |=> working_register == $past(mem_rdata)
    && result_null_bit == (working_register == 8'h00) && $stable(unsigned_out_bit))
    else $error("memory load result or flags wrong");
  chk_timer_copy: assert property (
    tk && op_code == `ACD_OP_TLOAD |=> mem_we && mem_we_hi
    && {mem_wdata_hi, mem_wdata} == $past(timer_value))
    else $error("timer word not written");
  chk_idx_two: assert property (
    tk && (op_code == `ACD_OP_IDX_RD || op_code == `ACD_OP_IDX_WR)
    |=> op_busy && ind_req && !op_done ##1 op_done)
    else $error("indirect move not two cycles");
  chk_xch_swap: assert property (
    tk && op_code == `ACD_OP_XCH |=> working_register == $past(mem_rdata)
    && mem_wdata == $past(working_register) && $stable(result_null_bit))
    else $error("exchange did not swap cleanly");
  chk_push_step: assert property (
    tk && op_code == `ACD_OP_PUSHF |=> mem_we && push_pointer == $past(push_pointer) + 8'h02)
    else $error("push pointer step wrong");
  chk_pop_step: assert property (
    tk && op_code == `ACD_OP_POPF |=> push_pointer == $past(push_pointer) - 8'h02)
    else $error("pop pointer step wrong");
  chk_clear_zero: assert property (
    tk && op_code == `ACD_OP_CLR_M |=> mem_we && mem_wdata == 8'h00 && $stable(unsigned_out_bit))
    else $error("clear wrote nonzero or moved carry");
  // ==========================================================
  // Coverage of main scenarios
  cover property (tk && op_code == `ACD_OP_IDX_RD);
  cover property (tk && op_code == `ACD_OP_POPF);
  cover property (tk && op_code == `ACD_OP_ADD_AI && sum[DW]);
endmodule
bind acd_datapath acd_datapath_assertions #(.DW(DW), .TW(TW)) u_chk (
  .clock(clock), .rst(rst), .op_valid(op_valid), .op_busy(op_busy), .op_code(op_code),
  .op_imm(op_imm), .mem_rdata(mem_rdata), .timer_value(timer_value), .op_done(op_done),
  .ind_req(ind_req), .mem_we(mem_we), .mem_we_hi(mem_we_hi), .mem_wdata(mem_wdata),
  .mem_wdata_hi(mem_wdata_hi), .working_register(working_register),
  .push_pointer(push_pointer), .result_null_bit(result_null_bit),
  .unsigned_out_bit(unsigned_out_bit));

/* File: dv/tb.sv */
// Self-checking bench for the accumulator datapath
`timescale 1ns/1ps
`include "acd_map.vh"
module tb;
  // ==========================================================
  // Stimulus, driven on the falling edge
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg op_valid = 1'b0;
  reg [4:0] op_code = 5'h00;
  reg [7:0] op_imm = 8'h00;
  reg [7:0] op_addr = 8'h21;
  reg [7:0] mem_rdata = 8'h00;
  reg [7:0] mem_rdata_hi = 8'h00;
  reg [7:0] io_rdata = 8'h00;
  reg [15:0] timer_value = 16'h0000;
  // Design outputs
  wire op_busy, op_done, mem_we, mem_we_hi, io_we, timer_we, ind_req, bit_addr_ok;
  wire [7:0] mem_waddr, mem_wdata, mem_wdata_hi, io_wdata, ind_addr, wr, pp;
  wire [15:0] timer_wdata;
  wire z, c, ac, ov;
  // Flags packed in saved-byte order
  wire [3:0] fl = {ov, ac, c, z};
  reg [7:0] p0;
  integer failures = 0;
  integer checks = 0;
  always #2.5 clock = ~clock;
  acd_datapath DUT (
    .clock(clock), .rst(rst), .op_valid(op_valid), .op_code(op_code), .op_imm(op_imm),
    .op_addr(op_addr), .op_busy(op_busy), .op_done(op_done), .mem_rdata(mem_rdata),
    .mem_rdata_hi(mem_rdata_hi), .io_rdata(io_rdata), .timer_value(timer_value),
    .mem_we(mem_we), .mem_we_hi(mem_we_hi), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata),
    .mem_wdata_hi(mem_wdata_hi), .io_we(io_we), .io_wdata(io_wdata), .timer_we(timer_we),
    .timer_wdata(timer_wdata), .ind_req(ind_req), .ind_addr(ind_addr),
    .working_register(wr), .push_pointer(pp), .result_null_bit(z), .unsigned_out_bit(c),
    .half_byte_out_bit(ac), .signed_range_bit(ov), .bit_addr_ok(bit_addr_ok));
  // ==========================================================
  // Shared tasks
  // One op per cycle; valid stays up so no signal is set twice in a step
  task op(input [4:0] cd, input [7:0] im, input [7:0] md);
    begin
      op_code = cd;
      op_imm = im;
      mem_rdata = md;
      op_valid = 1'b1;
      @(negedge clock);
    end
  endtask
  // Compare and count
  task ck(input [63:0] nm, input [15:0] ex, input [15:0] gt);
    begin
      checks = checks + 1;
      if (gt !== ex) begin
        $display("BAD %0s expected %h seen %h", nm, ex, gt);
        failures = failures + 1;
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask
  // ==========================================================
  // Scenarios
  // Bit-operand address flag at the edge of the allowed range; no op is issued
  task t_bitaddr;
    begin
      op_addr = 8'h3F;
      @(negedge clock);
      ck("bitok", 16'h0001, {15'h0000, bit_addr_ok});
      op_addr = 8'h40;
      @(negedge clock);
      ck("bitbad", 16'h0000, {15'h0000, bit_addr_ok});
      // Later ops keep their operand inside the bit-addressable range
      op_addr = 8'h21;
    end
  endtask
  // Add forms: nibble carry, signed overflow, wrap to zero, carry in
  task t_add;
    begin
      op(`ACD_OP_MOV_AI, 8'h7F, 8'h00);
      op(`ACD_OP_ADD_AI, 8'h01, 8'h00);
      ck("add1", 16'h0C80, {4'h0, fl, wr});
      op(`ACD_OP_ADD_AI, 8'h80, 8'h00);
      ck("add2", 16'h0B00, {4'h0, fl, wr});
      op(`ACD_OP_ADDC_A, 8'h00, 8'h00);
      ck("adc", 16'h0001, {4'h0, fl, wr});
      op(`ACD_OP_ADD_MA, 8'h00, 8'h0F);
      ck("addm", 16'h0110, {7'h00, mem_we, mem_wdata});
      ck("addmf", 16'h0004, {12'h000, fl});
      op(`ACD_OP_ADD_AM, 8'h00, 8'hFF);
      ck("addam", 16'h0700, {4'h0, fl, wr});
      op(`ACD_OP_ADDC_AM, 8'h00, 8'h10);
      ck("adcam", 16'h0011, {4'h0, fl, wr});
      op(`ACD_OP_ADDC_MA, 8'h00, 8'hEF);
      ck("adcma", 16'h1700, {3'h0, mem_we, fl, mem_wdata});
      op(`ACD_OP_ADDC_M, 8'h00, 8'h7F);
      ck("adcm", 16'h0C80, {4'h0, fl, mem_wdata});
    end
  endtask
  // Subtract forms: borrows and subtract-with-borrow
  task t_sub;
    begin
      op(`ACD_OP_MOV_AI, 8'h10, 8'h00);
      op(`ACD_OP_SUB_AI, 8'h01, 8'h00);
      ck("sub1", 16'h040F, {4'h0, fl, wr});
      op(`ACD_OP_SUB_AM, 8'h00, 8'h10);
      ck("sub2", 16'h02FF, {4'h0, fl, wr});
      op(`ACD_OP_SUBC_A, 8'h00, 8'h00);
      ck("sbc", 16'h00FE, {4'h0, fl, wr});
      op(`ACD_OP_MOV_AI, 8'h05, 8'h00);
      op(`ACD_OP_NADD_AM, 8'h00, 8'h03);
      ck("nadd", 16'h06FE, {4'h0, fl, wr});
      op(`ACD_OP_NADD_MA, 8'h00, 8'h01);
      ck("naddm", 16'h00FD, {4'h0, fl, mem_wdata});
      op(`ACD_OP_SUB_MA, 8'h00, 8'h7F);
      ck("subm", 16'h0A81, {4'h0, fl, mem_wdata});
      op(`ACD_OP_SUBC_AM, 8'h00, 8'h0E);
      ck("sbcam", 16'h04EF, {4'h0, fl, wr});
      op(`ACD_OP_SUBC_MA, 8'h00, 8'hE0);
      ck("sbcma", 16'h06F1, {4'h0, fl, mem_wdata});
      op(`ACD_OP_SUBC_M, 8'h00, 8'h00);
      ck("sbcm", 16'h06FF, {4'h0, fl, mem_wdata});
    end
  endtask
  // Loads touch only zero; clear leaves flags
  task t_load;
    begin
      op(`ACD_OP_MOV_AI, 8'hFF, 8'h00);
      op(`ACD_OP_ADD_AI, 8'h01, 8'h00);
      op(`ACD_OP_MOV_AM, 8'h00, 8'h40);
      ck("ldm", 16'h0640, {4'h0, fl, wr});
      io_rdata = 8'h00;
      op(`ACD_OP_MOV_AIO, 8'h00, 8'h00);
      ck("ldio", 16'h0700, {4'h0, fl, wr});
      op(`ACD_OP_CLR_M, 8'h00, 8'h55);
      ck("clr", 16'h1700, {3'h0, mem_we, fl, mem_wdata});
      op(`ACD_OP_MOV_AI, 8'h3C, 8'h00);
      op(`ACD_OP_MOV_MA, 8'h00, 8'h00);
      ck("stm", 16'h173C, {3'h0, mem_we, fl, mem_wdata});
      op(`ACD_OP_MOV_IOA, 8'h00, 8'h00);
      ck("stio", 16'h173C, {3'h0, io_we, fl, io_wdata});
    end
  endtask
  // Timer word copies both ways
  task t_timer;
    begin
      timer_value = 16'hA55A;
      op(`ACD_OP_TLOAD, 8'h00, 8'h00);
      ck("tld", 16'hA55A, {mem_wdata_hi, mem_wdata});
      ck("tldwe", 16'h0003, {14'h0000, mem_we, mem_we_hi});
      mem_rdata_hi = 8'h12;
      op(`ACD_OP_TSTORE, 8'h00, 8'h34);
      ck("tst", 16'h1234, timer_wdata);
      ck("tstwe", 16'h0001, {15'h0000, timer_we});
    end
  endtask
  // Indirect moves; an add offered while busy must be ignored
  task t_idx;
    begin
      op(`ACD_OP_IDX_RD, 8'h00, 8'h40);
      ck("ireq", 16'h0340, {6'h00, ind_req, op_busy, ind_addr});
      op(`ACD_OP_ADD_AI, 8'h01, 8'h9D);
      ck("ird", 16'h019D, {7'h00, op_done, wr});
      op(`ACD_OP_IDX_WR, 8'h00, 8'h41);
      op(`ACD_OP_NOP, 8'h00, 8'h00);
      ck("iwr", 16'h419D, {mem_waddr, mem_wdata});
      ck("iwrwe", 16'h0001, {15'h0000, mem_we});
    end
  endtask
  // Exchange, then push and pop of flags with the register
  task t_stack;
    begin
      op(`ACD_OP_XCH, 8'h00, 8'h11);
      ck("xch", 16'h119D, {wr, mem_wdata});
      ck("xchf", 16'h0007, {12'h000, fl});
      p0 = pp;
      op(`ACD_OP_PUSHF, 8'h00, 8'h00);
      ck("push", {p0 + 8'h02, p0}, {pp, mem_waddr});
      ck("pushd", 16'h0711, {mem_wdata_hi, mem_wdata});
      mem_rdata_hi = 8'h0F;
      op(`ACD_OP_POPF, 8'h00, 8'h00);
      ck("pop", {p0, 4'h0, 4'hF}, {pp, wr[3:0], fl});
    end
  endtask
  // Increment and decrement across wrap and sign boundaries
  task t_incdec;
    begin
      op(`ACD_OP_INC_M, 8'h00, 8'hFF);
      ck("inc", 16'h0700, {4'h0, fl, mem_wdata});
      op(`ACD_OP_DEC_M, 8'h00, 8'h80);
      ck("dec", 16'h0C7F, {4'h0, fl, mem_wdata});
    end
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (10) @(negedge clock);
    rst = 1'b0;
    ck("rst", 16'h0000, {wr, pp});
    t_bitaddr;
    t_add;
    t_sub;
    t_load;
    t_timer;
    t_idx;
    t_stack;
    t_incdec;
    final_report;
  end
  // Whole run needs well under 100 cycles
  initial begin
    #10000;
    failures = failures + 1;
    final_report;
  end
endmodule
